// ===== logic/e1sab_pkg.sv
// Notes on behaviour
// - Five transmit national-bit bytes sit at offsets 0x10 to 0x14 of page 0x0D, numbered 0 to 4.
// - Transmit national-bit bytes reach the line only while the buffer enable bit is one.
// - Transmit byte n supplies bit position n+4 of timeslot zero in the eight odd frames.
// - Five receive national-bit bytes sit at offsets 0x10 to 0x14 of page 0x0E, numbered 0 to 4.
// - Receive byte n captures bit position n+4 of timeslot zero in the eight odd frames.
// - There are 32 transmit message bytes over two pages, one per line timeslot.
// - A timeslot sends its message byte only while its message-transmit select bit 7 is set.
// - Transmit message buffer zero, page 0x0F offsets 0x10 to 0x1F, drives timeslots 0 to 15.
// - Transmit message buffer one, page 0x10 offsets 0x10 to 0x1F, drives timeslots 16 to 31.
// - Each of the 32 receive message bytes on pages 0x11 and 0x12 is rewritten every frame.
// - Receive message buffer zero, page 0x11 offsets 0x10 to 0x1F, holds timeslots 0 to 15.
// - Receive message buffer one, page 0x12 offsets 0x10 to 0x1F, holds timeslots 16 to 31.
package e1sab_pkg;

  // ==========================================================
  // register map, index = page * 32 + offset, byte address = 4 * index
  localparam int AXI_ADDR_W = 12;
  localparam logic [4:0] PAGE_CTRL = 5'h01;
  localparam logic [4:0] PAGE_TSCTL0 = 5'h07;
  localparam logic [4:0] PAGE_TSCTL1 = 5'h08;
  localparam logic [4:0] PAGE_TXNB = 5'h0D;
  localparam logic [4:0] PAGE_RXNB = 5'h0E;
  localparam logic [4:0] PAGE_TXMSG0 = 5'h0F;
  localparam logic [4:0] PAGE_TXMSG1 = 5'h10;
  localparam logic [4:0] PAGE_RXMSG0 = 5'h11;
  localparam logic [4:0] PAGE_RXMSG1 = 5'h12;
  localparam logic [4:0] OFF_BASE = 5'h10;
  localparam logic [4:0] OFF_NB_LAST = 5'h14;
  localparam logic [4:0] OFF_CTRL = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h11;

  // ==========================================================
  // fields and reset values
  localparam int NB_BYTES = 5;
  localparam int NB_EN_BIT = 0;
  localparam int MSG_SEL_BIT = 7;
  localparam int SA_TOP_BIT = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CLS_NONE,
    CLS_CTRL,
    CLS_STATUS,
    CLS_TSCTL,
    CLS_TXNB,
    CLS_RXNB,
    CLS_MESSAGE_TRANSMIT_SELECT,
    CLS_RXMSG
  } e1sab_class_type;

  // ==========================================================
  // address decode shared by the read and write paths
  function automatic e1sab_class_type e1sab_decode(input logic [9:0] idx);
    logic [4:0] page;
    logic [4:0] off;
    logic in_nb;
    e1sab_class_type cls;
    page = idx[9:5];
    off = idx[4:0];
    in_nb = (off >= OFF_BASE) && (off <= OFF_NB_LAST);
    cls = CLS_NONE;
    if (page == PAGE_CTRL && off == OFF_CTRL) begin
      cls = CLS_CTRL;
    end else if (page == PAGE_CTRL && off == OFF_STATUS) begin
      cls = CLS_STATUS;
    end else if ((page == PAGE_TSCTL0 || page == PAGE_TSCTL1) && off[4]) begin
      cls = CLS_TSCTL;
    end else if (page == PAGE_TXNB && in_nb) begin
      cls = CLS_TXNB;
    end else if (page == PAGE_RXNB && in_nb) begin
      cls = CLS_RXNB;
    end else if ((page == PAGE_TXMSG0 || page == PAGE_TXMSG1) && off[4]) begin
      cls = CLS_MESSAGE_TRANSMIT_SELECT;
    end else if ((page == PAGE_RXMSG0 || page == PAGE_RXMSG1) && off[4]) begin
      cls = CLS_RXMSG;
    end
    return cls;
  endfunction : e1sab_decode

endpackage : e1sab_pkg

// ===== logic/e1sab_mem.sv
`timescale 1ns/100ps
// ==========================================================
// one write port, two registered read ports
module e1sab_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr_a,
  output logic [WIDTH-1:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_b
);

  // no reset on the array, it maps onto plain ram
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end

endmodule : e1sab_mem

// ===== logic/e1sab_oddfrm.sv
`timescale 1ns/100ps
// ==========================================================
// odd-frame position of timeslot zero within the eight-frame group
module e1sab_oddfrm (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic strobe,
  input wire logic crc4_mode,
  input wire logic [3:0] frame,
  input wire logic [4:0] slot,
  output logic sa_frame,
  output logic [2:0] frame_index
);

  logic [2:0] count;

  assign sa_frame = strobe && (slot == 5'h00) && frame[0];
  // multiframe number pins frame 1 to index 0; otherwise count odd frames
  assign frame_index = crc4_mode ? frame[3:1] : count;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 3'h0;
    end else if (sa_frame) begin
      count <= 3'(count + 3'h1);
    end
  end

endmodule : e1sab_oddfrm

// ===== logic/e1sab_top.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
module e1sab_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic crc4_mode,
  input wire logic tx_slot_strobe,
  input wire logic [3:0] tx_frame,
  input wire logic [4:0] tx_slot,
  input wire logic [7:0] tx_normal_data,
  output logic tx_line_valid,
  output logic [7:0] tx_line_data,
  input wire logic rx_slot_strobe,
  input wire logic [3:0] rx_frame,
  input wire logic [4:0] rx_slot,
  input wire logic [7:0] rx_line_data
);

  localparam int NB = e1sab_pkg::NB_BYTES;
  localparam logic [9:0] IDX_TXNB0 = {e1sab_pkg::PAGE_TXNB, e1sab_pkg::OFF_BASE};
  localparam logic [9:0] IDX_RXNB4 = {e1sab_pkg::PAGE_RXNB, e1sab_pkg::OFF_NB_LAST};

  // ==========================================================
  // control and buffer state
  logic national_bit_buffer_enable;
  logic [31:0] message_transmit_select;
  logic [7:0] tx_national_bits [NB];
  logic [7:0] rx_national_bits [NB];

  // ==========================================================
  // write channel, address and data taken in either order
  logic aw_hold;
  logic w_hold;
  logic [9:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane0;
  logic next_aw_hold;
  logic next_w_hold;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  wire e1sab_pkg::e1sab_class_type wr_cls = e1sab_pkg::e1sab_decode(aw_idx);
  wire wr_do = wr_fire && w_lane0;
  wire wr_page_hi = (aw_idx[9:5] == e1sab_pkg::PAGE_TXMSG1) ||
                    (aw_idx[9:5] == e1sab_pkg::PAGE_TSCTL1);
  wire [4:0] wr_slot = {wr_page_hi, aw_idx[3:0]};
  wire wr_legal = (wr_cls == e1sab_pkg::CLS_CTRL) || (wr_cls == e1sab_pkg::CLS_TSCTL) ||
                  (wr_cls == e1sab_pkg::CLS_TXNB) || (wr_cls == e1sab_pkg::CLS_MESSAGE_TRANSMIT_SELECT);
  wire txm_we = wr_do && (wr_cls == e1sab_pkg::CLS_MESSAGE_TRANSMIT_SELECT);

  assign next_aw_hold = wr_fire ? 1'b0 : (aw_hold || aw_take);
  assign next_w_hold = wr_fire ? 1'b0 : (w_hold || w_take);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      s_axi_awready <= !next_aw_hold;
      s_axi_wready <= !next_w_hold;
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_take) begin
      aw_idx <= s_axi_awaddr[11:2];
    end
    if (w_take) begin
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= e1sab_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_legal ? e1sab_pkg::RESP_OKAY : e1sab_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // software-written registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      national_bit_buffer_enable <= 1'b0;
      message_transmit_select <= '0;
    end else begin
      if (wr_do && wr_cls == e1sab_pkg::CLS_CTRL) begin
        national_bit_buffer_enable <= w_byte[e1sab_pkg::NB_EN_BIT];
      end
      if (wr_do && wr_cls == e1sab_pkg::CLS_TSCTL) begin
        message_transmit_select[wr_slot] <= w_byte[e1sab_pkg::MSG_SEL_BIT];
      end
    end
  end

  for (genvar i = 0; i < NB; i++) begin : g_txnb
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        tx_national_bits[i] <= e1sab_pkg::RST_BYTE;
      end else if (wr_do && wr_cls == e1sab_pkg::CLS_TXNB && aw_idx[2:0] == 3'(i)) begin
        tx_national_bits[i] <= w_byte;
      end
    end
  end

  // ==========================================================
  // read channel, answer two cycles after the address is taken
  logic rd_stage;
  logic [9:0] rd_idx;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [9:0] ar_idx = s_axi_araddr[11:2];
  wire ar_page_hi = (ar_idx[9:5] == e1sab_pkg::PAGE_TXMSG1) ||
                    (ar_idx[9:5] == e1sab_pkg::PAGE_RXMSG1);
  wire [4:0] ar_slot = {ar_page_hi, ar_idx[3:0]};
  wire e1sab_pkg::e1sab_class_type rd_cls = e1sab_pkg::e1sab_decode(rd_idx);
  wire [2:0] rd_nb = (rd_idx[2:0] < 3'(NB)) ? rd_idx[2:0] : 3'h0;
  wire [4:0] rd_ts = {rd_idx[9:5] == e1sab_pkg::PAGE_TSCTL1, rd_idx[3:0]};
  wire [7:0] txm_bus_q;
  wire [7:0] rxm_bus_q;
  wire [7:0] txm_line_q;
  wire [2:0] tx_k;
  wire [2:0] rx_k;
  wire tx_sa;
  wire rx_sa;
  wire [7:0] status_byte = {crc4_mode, rx_k, 1'b0, tx_k};
  wire [7:0] rd_byte =
    (rd_cls == e1sab_pkg::CLS_CTRL) ? {7'h00, national_bit_buffer_enable} :
    (rd_cls == e1sab_pkg::CLS_STATUS) ? status_byte :
    (rd_cls == e1sab_pkg::CLS_TSCTL) ? {message_transmit_select[rd_ts], 7'h00} :
    (rd_cls == e1sab_pkg::CLS_TXNB) ? tx_national_bits[rd_nb] :
    (rd_cls == e1sab_pkg::CLS_RXNB) ? rx_national_bits[rd_nb] :
    (rd_cls == e1sab_pkg::CLS_MESSAGE_TRANSMIT_SELECT) ? txm_bus_q :
    (rd_cls == e1sab_pkg::CLS_RXMSG) ? rxm_bus_q : 8'h00;

  always_ff @(posedge aclk) begin
    if (ar_take) begin
      rd_idx <= ar_idx;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_stage <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= e1sab_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rd_stage <= 1'b1;
      s_axi_arready <= 1'b0;
    end else if (rd_stage) begin
      rd_stage <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= (rd_cls == e1sab_pkg::CLS_NONE) ? e1sab_pkg::RESP_SLVERR
                                                      : e1sab_pkg::RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // message buffers, one slot-addressed byte each
  e1sab_mem #(.WIDTH(8), .DEPTH(32), .AW(5)) u_message_transmit_select (
    .aclk(aclk),
    .we(txm_we),
    .waddr(wr_slot),
    .wdata(w_byte),
    .raddr_a(tx_slot),
    .rdata_a(txm_line_q),
    .raddr_b(ar_slot),
    .rdata_b(txm_bus_q)
  );

  // every received slot lands, so each byte is refreshed once per frame
  e1sab_mem #(.WIDTH(8), .DEPTH(32), .AW(5)) u_rxmsg (
    .aclk(aclk),
    .we(rx_slot_strobe),
    .waddr(rx_slot),
    .wdata(rx_line_data),
    .raddr_a(rx_slot),
    .rdata_a(),
    .raddr_b(ar_slot),
    .rdata_b(rxm_bus_q)
  );

  // ==========================================================
  // frame position of the national bits
  e1sab_oddfrm u_tx_odd (
    .aclk(aclk),
    .aresetn(aresetn),
    .strobe(tx_slot_strobe),
    .crc4_mode(crc4_mode),
    .frame(tx_frame),
    .slot(tx_slot),
    .sa_frame(tx_sa),
    .frame_index(tx_k)
  );

  e1sab_oddfrm u_rx_odd (
    .aclk(aclk),
    .aresetn(aresetn),
    .strobe(rx_slot_strobe),
    .crc4_mode(crc4_mode),
    .frame(rx_frame),
    .slot(rx_slot),
    .sa_frame(rx_sa),
    .frame_index(rx_k)
  );

  // ==========================================================
  // transmit path, one stage to meet the registered message read
  logic s1_valid;
  logic s1_sa;
  logic s1_msg;
  logic [4:0] s1_slot;
  logic [2:0] s1_k;
  logic [7:0] s1_data;
  logic [4:0] sa_bits;
  wire [7:0] base_byte = s1_msg ? txm_line_q : s1_data;
  wire sa_insert = s1_sa && national_bit_buffer_enable;
  wire [7:0] next_tx_data = sa_insert ? {base_byte[7:5], sa_bits} : base_byte;

  // byte n feeds bit n+4, counted from the msb as bit 1
  for (genvar n = 0; n < NB; n++) begin : g_sabit
    assign sa_bits[e1sab_pkg::SA_TOP_BIT - n] = tx_national_bits[n][~s1_k];
  end

  always_ff @(posedge aclk) begin
    s1_slot <= tx_slot;
    s1_k <= tx_k;
    s1_data <= tx_normal_data;
    s1_msg <= message_transmit_select[tx_slot];
    s1_sa <= tx_sa;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_valid <= 1'b0;
      tx_line_valid <= 1'b0;
      tx_line_data <= e1sab_pkg::RST_BYTE;
    end else begin
      s1_valid <= tx_slot_strobe;
      tx_line_valid <= s1_valid;
      if (s1_valid) begin
        tx_line_data <= next_tx_data;
      end
    end
  end

  // ==========================================================
  // receive national bits, written bit by bit as frames arrive
  for (genvar n = 0; n < NB; n++) begin : g_rxnb
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rx_national_bits[n] <= e1sab_pkg::RST_BYTE;
      end else if (rx_sa) begin
        rx_national_bits[n][~rx_k] <= rx_line_data[e1sab_pkg::SA_TOP_BIT - n];
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_rd_take(logic [9:0] idx);
    ar_take && ar_idx == idx;
  endsequence

  sequence s_sa_slot_live;
    s1_valid && s1_sa && national_bit_buffer_enable && !s1_msg;
  endsequence

  a_txnb_read_map: assert property (
    s_rd_take(IDX_TXNB0) |->
      ##2 (s_axi_rvalid && s_axi_rdata[7:0] == $past(tx_national_bits[0])))
    else $error("tx national byte 0 read back wrong");

  a_rxnb_read_map: assert property (
    s_rd_take(IDX_RXNB4) |->
      ##2 (s_axi_rvalid && s_axi_rdata[7:0] == $past(rx_national_bits[4])))
    else $error("rx national byte 4 read back wrong");

  a_nbit_off_pass: assert property (
    s1_valid && !national_bit_buffer_enable && !s1_msg |=> tx_line_data == $past(s1_data))
    else $error("national bits inserted while disabled");

  a_sa_insert_order: assert property (
    s_sa_slot_live |=> tx_line_data[4] == $past(tx_national_bits[0][~s1_k]) &&
                       tx_line_data[0] == $past(tx_national_bits[4][~s1_k]) &&
                       tx_line_data[7:5] == $past(s1_data[7:5]))
    else $error("national bit placed in wrong position");

  a_sa_frame_one: assert property (
    tx_slot_strobe && tx_sa && crc4_mode && tx_frame == 4'h1 ##1 s1_valid
      |=> !national_bit_buffer_enable || $past(s1_msg) ||
          tx_line_data[4] == $past(tx_national_bits[0][7]))
    else $error("frame 1 did not use bit 7");

  a_sa_capture: assert property (
    rx_sa |=> rx_national_bits[0][~$past(rx_k)] == $past(rx_line_data[4]) &&
              rx_national_bits[4][~$past(rx_k)] == $past(rx_line_data[0]))
    else $error("received national bit not captured");

  a_msg_send: assert property (
    tx_slot_strobe && message_transmit_select[tx_slot] && tx_slot != 5'h00
      ##2 tx_line_valid |-> tx_line_data == $past(txm_line_q))
    else $error("selected slot did not carry message byte");

  a_msg_bypass: assert property (
    s1_valid && !s1_msg && s1_slot != 5'h00 |=> tx_line_valid && tx_line_data == $past(s1_data))
    else $error("unselected slot lost its normal data");

  // the byte must land in the slot named by page and offset, not just leave the port
  a_message_transmit_select_slot_map: assert property (
    txm_we |=> u_message_transmit_select.mem[{$past(aw_idx[9:5]) == e1sab_pkg::PAGE_TXMSG1,
                            $past(aw_idx[3:0])}] == $past(w_byte))
    else $error("message write went to wrong slot");

  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");

endmodule : e1sab_top

// ===== sim/e1sab_framer_model.sv
`timescale 1ns/100ps
// ==========================================================
// line-side framer: walks slot 0..31 of frames 0..15
module e1sab_framer_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic fast,
  output logic tx_slot_strobe,
  output logic [3:0] tx_frame,
  output logic [4:0] tx_slot,
  output logic [7:0] tx_normal_data,
  output logic rx_slot_strobe,
  output logic [3:0] rx_frame,
  output logic [4:0] rx_slot,
  output logic [7:0] rx_line_data
);
  logic [8:0] pos;
  logic [15:0] lfsr;
  logic gap;
  wire logic fire = run && (fast || gap);
  always @(posedge aclk) begin
    if (!aresetn) begin
      pos <= 9'h000;
      lfsr <= 16'hACE1;
      gap <= 1'b0;
      {tx_slot_strobe, rx_slot_strobe, tx_frame, tx_slot, rx_frame, rx_slot} <= '0;
      tx_normal_data <= 8'h00;
      rx_line_data <= 8'h00;
    end else begin
      gap <= !gap;
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      tx_slot_strobe <= fire;
      rx_slot_strobe <= fire;
      if (fire) begin
        {tx_frame, tx_slot} <= pos;
        {rx_frame, rx_slot} <= pos;
        tx_normal_data <= lfsr[7:0];
        rx_line_data <= lfsr[15:8];
        pos <= pos + 9'h001;
      end else begin
        // stale bytes must never pass for fresh ones
        tx_normal_data <= ~tx_normal_data;
        rx_line_data <= ~rx_line_data;
      end
    end
  end
endmodule : e1sab_framer_model

// ===== sim/e1sab_top_bench.sv
`timescale 1ns/100ps
module e1sab_top_bench;
  logic aclk, aresetn, crc4_mode, run, fast, en;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic tx_slot_strobe, rx_slot_strobe, tx_line_valid;
  wire logic [7:0] tx_line_data, tx_normal_data, rx_line_data;
  wire logic [3:0] tx_frame, rx_frame;
  wire logic [4:0] tx_slot, rx_slot;
  int miscompares, n_compared, seed, tkc, rkc;
  logic [7:0] tnb [5], rnb [5], msg [32], rxm [32];
  logic sel [32];
  logic v1 = 1'b0, v2 = 1'b0;
  logic [7:0] e1, e2;

  e1sab_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .crc4_mode, .tx_slot_strobe, .tx_frame, .tx_slot,
    .tx_normal_data, .tx_line_valid, .tx_line_data, .rx_slot_strobe, .rx_frame, .rx_slot,
    .rx_line_data);
  e1sab_framer_model line_side (.aclk, .aresetn, .run, .fast, .tx_slot_strobe, .tx_frame,
    .tx_slot, .tx_normal_data, .rx_slot_strobe, .rx_frame, .rx_slot, .rx_line_data);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ==========================================================
  // compare and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic tmo();
    miscompares++;
    close_out();
  endtask : tmo

  // ==========================================================
  // register bus master
  function automatic logic [11:0] ad(input logic [4:0] pg, input logic [4:0] off);
    return {pg, off, 2'b00};
  endfunction : ad

  function automatic logic [11:0] sa(input logic [4:0] p0, input logic [4:0] p1, input int i);
    return ad(i > 15 ? p1 : p0, e1sab_pkg::OFF_BASE | 5'(i % 16));
  endfunction : sa

  task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [3:0] st,
    input logic [1:0] er);
    int i;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    i = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (i > 200) tmo();
    end while (aw || w);
    // the response can never share the edge of the last take
    do begin
      @(posedge aclk);
      i++;
      if (i > 400) tmo();
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    // let an edge pass so the next call never reassigns bready in this step
    @(posedge aclk);
  endtask : axw

  task automatic axr(input logic [11:0] a, input logic [1:0] er, output logic [31:0] rd);
    int i;
    i = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
      if (i > 200) tmo();
    end while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      i++;
      if (i > 400) tmo();
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axr

  // ==========================================================
  // line monitor: expected byte two edges after each strobe
  always @(posedge aclk) begin : mon
    logic [7:0] b;
    int k;
    if (v2 || tx_line_valid === 1'b1) chk(tx_line_valid, v2);
    if (v2) chk(tx_line_data, e2);
    v2 <= v1;
    e2 <= e1;
    v1 <= (tx_slot_strobe === 1'b1);
    if (tx_slot_strobe === 1'b1) begin
      b = sel[tx_slot] ? msg[tx_slot] : tx_normal_data;
      if (tx_slot == 5'h00 && tx_frame[0]) begin
        k = crc4_mode ? int'(tx_frame[3:1]) : tkc % 8;
        tkc++;
        if (en) for (int n = 0; n < 5; n++) b[4-n] = tnb[n][7-k];
      end
      e1 <= b;
    end
    if (rx_slot_strobe === 1'b1) begin
      rxm[rx_slot] = rx_line_data;
      if (rx_slot == 5'h00 && rx_frame[0]) begin
        k = crc4_mode ? int'(rx_frame[3:1]) : rkc % 8;
        rkc++;
        for (int n = 0; n < 5; n++) rnb[n][7-k] = rx_line_data[4-n];
      end
    end
  end

  // ==========================================================
  // scenario helpers
  task automatic load_all();
    logic [31:0] rd;
    for (int n = 0; n < 5; n++) begin
      tnb[n] = 8'($random(seed));
      axw(ad(e1sab_pkg::PAGE_TXNB, e1sab_pkg::OFF_BASE + 5'(n)), tnb[n], 4'h1, 2'h0);
      axr(ad(e1sab_pkg::PAGE_TXNB, e1sab_pkg::OFF_BASE + 5'(n)), 2'h0, rd);
      chk(rd, {24'h000000, tnb[n]});
    end
    for (int i = 0; i < 32; i++) begin
      msg[i] = 8'($random(seed));
      sel[i] = 1'($random(seed));
      axw(sa(e1sab_pkg::PAGE_TXMSG0, e1sab_pkg::PAGE_TXMSG1, i), msg[i], 4'h1, 2'h0);
      axw(sa(e1sab_pkg::PAGE_TSCTL0, e1sab_pkg::PAGE_TSCTL1, i), {sel[i], 7'h55}, 4'h1, 2'h0);
      axr(sa(e1sab_pkg::PAGE_TXMSG0, e1sab_pkg::PAGE_TXMSG1, i), 2'h0, rd);
      chk(rd, {24'h000000, msg[i]});
      axr(sa(e1sab_pkg::PAGE_TSCTL0, e1sab_pkg::PAGE_TSCTL1, i), 2'h0, rd);
      chk(rd, {24'h000000, sel[i], 7'h00});
    end
  endtask : load_all

  task automatic check_rx();
    logic [31:0] rd;
    for (int i = 0; i < 32; i++) begin
      axr(sa(e1sab_pkg::PAGE_RXMSG0, e1sab_pkg::PAGE_RXMSG1, i), 2'h0, rd);
      chk(rd, {24'h000000, rxm[i]});
    end
    for (int n = 0; n < 5; n++) begin
      axr(ad(e1sab_pkg::PAGE_RXNB, e1sab_pkg::OFF_BASE + 5'(n)), 2'h0, rd);
      chk(rd, {24'h000000, rnb[n]});
    end
  endtask : check_rx

  // registers only change while the line is idle, so the monitor stays exact
  task automatic go(input logic f, input int n);
    run <= 1'b1;
    fast <= f;
    repeat (n) @(posedge aclk);
    run <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : go

  // ==========================================================
  // main sequence
  initial begin : main
    logic [31:0] rd;
    seed = 32'h43C6;
    {miscompares, n_compared, tkc, rkc} = '0;
    {aresetn, crc4_mode, run, fast, en} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    for (int n = 0; n < 5; n++) rnb[n] = 8'h00;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axw(ad(e1sab_pkg::PAGE_RXNB, e1sab_pkg::OFF_BASE), 8'hFF, 4'h1, 2'h2);
    axw(ad(e1sab_pkg::PAGE_TXNB, e1sab_pkg::OFF_BASE), 8'hFF, 4'h0, 2'h0);
    for (int n = 0; n < 5; n++) begin
      axr(ad(e1sab_pkg::PAGE_TXNB, e1sab_pkg::OFF_BASE + 5'(n)), 2'h0, rd);
      chk(rd, 32'h00000000);
      axr(ad(e1sab_pkg::PAGE_RXNB, e1sab_pkg::OFF_BASE + 5'(n)), 2'h0, rd);
      chk(rd, 32'h00000000);
    end
    axr(ad(5'h1F, 5'h1F), 2'h2, rd);
    chk(rd, 32'h00000000);
    load_all();
    go(1'b0, 700);
    check_rx();
    axw(ad(e1sab_pkg::PAGE_CTRL, e1sab_pkg::OFF_STATUS), 8'hFF, 4'h1, 2'h2);
    axr(ad(e1sab_pkg::PAGE_CTRL, e1sab_pkg::OFF_STATUS), 2'h0, rd);
    chk(rd, {24'h000000, 1'b0, 3'(rkc % 8), 1'b0, 3'(tkc % 8)});
    en = 1'b1;
    axw(ad(e1sab_pkg::PAGE_CTRL, e1sab_pkg::OFF_CTRL), 8'h01, 4'h1, 2'h0);
    axr(ad(e1sab_pkg::PAGE_CTRL, e1sab_pkg::OFF_CTRL), 2'h0, rd);
    chk(rd, 32'h00000001);
    load_all();
    go(1'b1, 1100);
    check_rx();
    crc4_mode <= 1'b1;
    load_all();
    go(1'b0, 2200);
    check_rx();
    close_out();
  end
endmodule : e1sab_top_bench
